// *** src/cpu_stack_irq_pkg.sv ***
package cpu_stack_irq_pkg;

    localparam int            PC_W          = 24;
    localparam int            DATA_W        = 32;
    localparam int            EXT_W         = 40;
    localparam int            FLT_LSB_W     = 8;
    localparam int            REG_IDX_W     = 5;
    localparam int            IRQ_N         = 4;
    localparam int            IRQ_IDX_W     = 2;
    localparam int            GIE_BIT       = 13;
    localparam logic [4:0]    EXT_REG_COUNT = 5'h08;
    localparam logic [31:0]   STATUS_RESET  = 32'h00000000;
    localparam logic [3:0]    FLAG_RESET    = 4'h0;
    localparam logic [3:0]    MASK_RESET    = 4'h0;
    localparam logic [23:0]   VECTOR_BASE   = 24'h000001;
    localparam logic [7:0]    PC_PAD        = 8'h00;
    localparam logic [7:0]    FLT_ZERO      = 8'h00;

    typedef enum logic [3:0] {
        OP_CALL         = 4'h0,
        OP_RET_SUB      = 4'h1,
        OP_RET_IRQ      = 4'h2,
        OP_PUSH_INT     = 4'h3,
        OP_POP_INT      = 4'h4,
        OP_PUSH_FLT     = 4'h5,
        OP_POP_FLT      = 4'h6,
        OP_PTR_WRITE    = 4'h7,
        OP_FLAG_WRITE   = 4'h8,
        OP_MASK_WRITE   = 4'h9,
        OP_STATUS_WRITE = 4'hA,
        OP_IRQ_ENTRY    = 4'hB
    } op_e;

    typedef enum logic [1:0] {
        STATE_IDLE  = 2'b00,
        STATE_WRITE = 2'b01,
        STATE_READ  = 2'b10
    } state_e;

endpackage

// *** src/cpu_stack_irq_entry.sv ***
// Functional notes
// - Stack grows upward: push increments, pop decrements
// - Pointer addresses last pushed word always
// - Taken calls and interrupt entry push return address
// - Taken returns pop top word into PC
// - Integer push/pop moves any register's value
// - Integer push lower, float push upper 32
// - Float push/pop only for registers zero-seven
// - Float pop zeroes low eight bits
// - Stack pointer readable and writable by software
// - Reset leaves stack pointer unchanged
// - Request sets flag bit regardless of enables
// - Entry needs flag, enable and global enable
// - Flag writes force or discard requests
// - Flag register reads pending requests always
// - Entry loads serviced interrupt vector into PC
// - Entry clears global interrupt enable
// - Fixed priority, one vector per source
// - Only program counter saved automatically
// - Pushed and popped PC is 24 bits
// - Taken interrupt return sets global interrupt enable
// - Global enable is status bit 13, reset clears
`timescale 1ns/100ps
module cpu_stack_irq_entry
    import cpu_stack_irq_pkg::*;
(
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 op_valid_i,
    input  wire logic [3:0]           op_code_i,
    input  wire logic                 op_cond_i,
    input  wire logic [REG_IDX_W-1:0] op_reg_i,
    input  wire logic [DATA_W-1:0]    op_wdata_i,
    input  wire logic [EXT_W-1:0]     op_ext_i,
    input  wire logic [PC_W-1:0]      op_ret_pc_i,
    input  wire logic [PC_W-1:0]      op_target_i,
    input  wire logic [PC_W-1:0]      irq_ret_pc_i,
    input  wire logic [IRQ_N-1:0]     irq_req_i,
    input  wire logic [DATA_W-1:0]    mem_rdata_i,
    input  wire logic                 mem_ack_i,
    output logic                      op_ready_o,
    output logic                      op_done_o,
    output logic                      op_error_o,
    output logic                      mem_req_o,
    output logic                      mem_we_o,
    output logic [DATA_W-1:0]         mem_addr_o,
    output logic [DATA_W-1:0]         mem_wdata_o,
    output logic                      pc_load_o,
    output logic [PC_W-1:0]           pc_value_o,
    output logic                      reg_wr_o,
    output logic [REG_IDX_W-1:0]      reg_wr_idx_o,
    output logic [EXT_W-1:0]          reg_wr_data_o,
    output logic                      irq_ack_o,
    output logic [IRQ_IDX_W-1:0]      irq_ack_idx_o,
    output logic [DATA_W-1:0]         stack_top_pointer_o,
    output logic [IRQ_N-1:0]          irq_flag_o,
    output logic [IRQ_N-1:0]          irq_enable_mask_o,
    output logic [DATA_W-1:0]         cpu_status_word_o,
    output logic                      global_irq_enable_o
);

    state_e                 state_reg;
    state_e                 state_next;
    op_e                    kind_reg;
    logic [REG_IDX_W-1:0]   idx_reg;
    logic [EXT_W-1:0]       ext_reg;
    logic [PC_W-1:0]        target_reg;
    logic [IRQ_IDX_W-1:0]   irq_sel_reg;
    logic [DATA_W-1:0]      stack_reg;
    logic [DATA_W-1:0]      status_reg;
    logic [DATA_W-1:0]      status_next;
    logic [IRQ_N-1:0]       flag_reg;
    logic [IRQ_N-1:0]       flag_next;
    logic [IRQ_N-1:0]       mask_reg;
    logic [IRQ_N-1:0]       mask_next;
    logic [IRQ_N-1:0]       irq_meta_reg;
    logic [IRQ_N-1:0]       irq_sync_reg;
    logic [IRQ_N-1:0]       irq_prev_reg;
    logic [IRQ_N-1:0]       irq_rise;
    logic [IRQ_N-1:0]       pending;
    logic [IRQ_IDX_W-1:0]   irq_sel;
    logic                   irq_take;
    logic                   op_take;
    logic                   float_ok;
    logic                   start_write;
    logic                   start_read;
    logic                   write_done;
    logic                   read_done;
    logic                   ready_next;
    logic [DATA_W-1:0]      push_data;

    function automatic logic [IRQ_IDX_W-1:0] lowest_set(input logic [IRQ_N-1:0] vec);
        logic [IRQ_IDX_W-1:0] pos;
        pos = '0;
        for (int i = IRQ_N - 1; i >= 0; i--)
        begin
            if (vec[i])
            begin
                pos = IRQ_IDX_W'(i);
            end
        end
        return pos;
    endfunction

    // Requests are pins: two stages before the edge detector sees them
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            irq_meta_reg <= '0;
            irq_sync_reg <= '0;
            irq_prev_reg <= '0;
        end
        else
        begin
            irq_meta_reg <= irq_req_i;
            irq_sync_reg <= irq_meta_reg;
            irq_prev_reg <= irq_sync_reg;
        end
    end

    assign irq_rise    = irq_sync_reg & ~irq_prev_reg;
    assign pending     = flag_reg & mask_reg;
    assign irq_sel     = lowest_set(pending);
    assign irq_take    = (state_reg == STATE_IDLE) && (|pending) && status_reg[GIE_BIT];
    assign op_take     = op_valid_i && op_ready_o;
    assign float_ok    = op_reg_i < EXT_REG_COUNT;
    assign write_done  = (state_reg == STATE_WRITE) && mem_ack_i;
    assign read_done   = (state_reg == STATE_READ) && mem_ack_i;

    always_comb
    begin
        start_write = irq_take;
        start_read  = 1'b0;
        push_data   = {PC_PAD, irq_ret_pc_i};
        if (op_take)
        begin
            case (op_code_i)
                OP_CALL:
                begin
                    start_write = op_cond_i;
                    push_data   = {PC_PAD, op_ret_pc_i};
                end
                OP_PUSH_INT:
                begin
                    start_write = 1'b1;
                    push_data   = op_ext_i[DATA_W-1:0];
                end
                OP_PUSH_FLT:
                begin
                    start_write = float_ok;
                    push_data   = op_ext_i[EXT_W-1:FLT_LSB_W];
                end
                OP_RET_SUB, OP_RET_IRQ: start_read = op_cond_i;
                OP_POP_INT:             start_read = 1'b1;
                OP_POP_FLT:             start_read = float_ok;
                default:                start_read = 1'b0;
            endcase
        end
    end

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            STATE_IDLE:
            begin
                if (start_write)
                begin
                    state_next = STATE_WRITE;
                end
                else if (start_read)
                begin
                    state_next = STATE_READ;
                end
            end
            STATE_WRITE, STATE_READ:
            begin
                if (mem_ack_i)
                begin
                    state_next = STATE_IDLE;
                end
            end
            default: state_next = STATE_IDLE;
        endcase
    end

    always_comb
    begin
        status_next = status_reg;
        mask_next   = mask_reg;
        flag_next   = flag_reg;
        if (op_take && op_code_i == OP_STATUS_WRITE)
        begin
            status_next = op_wdata_i;
        end
        if (irq_take)
        begin
            status_next[GIE_BIT] = 1'b0;
            flag_next[irq_sel]   = 1'b0;
        end
        if (read_done && kind_reg == OP_RET_IRQ)
        begin
            status_next[GIE_BIT] = 1'b1;
        end
        if (op_take && op_code_i == OP_MASK_WRITE)
        begin
            mask_next = op_wdata_i[IRQ_N-1:0];
        end
        if (op_take && op_code_i == OP_FLAG_WRITE)
        begin
            flag_next = op_wdata_i[IRQ_N-1:0];
        end
        // A new edge beats any clear in the same cycle
        flag_next = flag_next | irq_rise;
    end

    // Ready is withheld whenever an entry will win the next idle cycle
    assign ready_next = (state_next == STATE_IDLE)
                        && !((|(flag_next & mask_next)) && status_next[GIE_BIT]);

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            status_reg <= STATUS_RESET;
            mask_reg   <= MASK_RESET;
            flag_reg   <= FLAG_RESET;
            state_reg  <= STATE_IDLE;
            op_ready_o <= 1'b0;
        end
        else
        begin
            status_reg <= status_next;
            mask_reg   <= mask_next;
            flag_reg   <= flag_next;
            state_reg  <= state_next;
            op_ready_o <= ready_next;
        end
    end

    // No reset on purpose: software must load the pointer before first use
    always_ff @(posedge clk_sys_i)
    begin
        if (op_take && op_code_i == OP_PTR_WRITE)
        begin
            stack_reg <= op_wdata_i;
        end
        else if (write_done)
        begin
            stack_reg <= stack_reg + 32'h00000001;
        end
        else if (read_done)
        begin
            stack_reg <= stack_reg - 32'h00000001;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            kind_reg    <= OP_CALL;
            idx_reg     <= '0;
            ext_reg     <= '0;
            target_reg  <= '0;
            irq_sel_reg <= '0;
        end
        else if (irq_take)
        begin
            kind_reg    <= OP_IRQ_ENTRY;
            irq_sel_reg <= irq_sel;
        end
        else if (op_take)
        begin
            kind_reg   <= op_e'(op_code_i);
            idx_reg    <= op_reg_i;
            ext_reg    <= op_ext_i;
            target_reg <= op_target_i;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            mem_req_o   <= 1'b0;
            mem_we_o    <= 1'b0;
            mem_addr_o  <= '0;
            mem_wdata_o <= '0;
        end
        else if (start_write)
        begin
            mem_req_o   <= 1'b1;
            mem_we_o    <= 1'b1;
            mem_addr_o  <= stack_reg + 32'h00000001;
            mem_wdata_o <= push_data;
        end
        else if (start_read)
        begin
            mem_req_o  <= 1'b1;
            mem_we_o   <= 1'b0;
            mem_addr_o <= stack_reg;
        end
        else if (mem_ack_i)
        begin
            mem_req_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            op_done_o     <= 1'b0;
            op_error_o    <= 1'b0;
            pc_load_o     <= 1'b0;
            pc_value_o    <= '0;
            reg_wr_o      <= 1'b0;
            reg_wr_idx_o  <= '0;
            reg_wr_data_o <= '0;
            irq_ack_o     <= 1'b0;
            irq_ack_idx_o <= '0;
        end
        else
        begin
            op_done_o  <= (op_take && !start_write && !start_read) || write_done || read_done;
            op_error_o <= op_take && !float_ok
                          && (op_code_i == OP_PUSH_FLT || op_code_i == OP_POP_FLT);
            irq_ack_o  <= irq_take;
            pc_load_o  <= 1'b0;
            reg_wr_o   <= 1'b0;
            if (irq_take)
            begin
                irq_ack_idx_o <= irq_sel;
            end
            if (write_done && kind_reg == OP_IRQ_ENTRY)
            begin
                pc_load_o  <= 1'b1;
                pc_value_o <= VECTOR_BASE + PC_W'(irq_sel_reg);
            end
            else if (write_done && kind_reg == OP_CALL)
            begin
                pc_load_o  <= 1'b1;
                pc_value_o <= target_reg;
            end
            if (read_done)
            begin
                case (kind_reg)
                    OP_RET_SUB, OP_RET_IRQ:
                    begin
                        pc_load_o  <= 1'b1;
                        pc_value_o <= mem_rdata_i[PC_W-1:0];
                    end
                    OP_POP_INT:
                    begin
                        reg_wr_o      <= 1'b1;
                        reg_wr_idx_o  <= idx_reg;
                        reg_wr_data_o <= {ext_reg[EXT_W-1:DATA_W], mem_rdata_i};
                    end
                    OP_POP_FLT:
                    begin
                        reg_wr_o      <= 1'b1;
                        reg_wr_idx_o  <= idx_reg;
                        reg_wr_data_o <= {mem_rdata_i, FLT_ZERO};
                    end
                    default: reg_wr_o <= 1'b0;
                endcase
            end
        end
    end

    assign stack_top_pointer_o = stack_reg;
    assign irq_flag_o          = flag_reg;
    assign irq_enable_mask_o   = mask_reg;
    assign cpu_status_word_o   = status_reg;
    assign global_irq_enable_o = status_reg[GIE_BIT];

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence entry_push_s;
        write_done && kind_reg == OP_IRQ_ENTRY;
    endsequence

    sequence irq_return_s;
        read_done && kind_reg == OP_RET_IRQ;
    endsequence

    push_addr_a: assert property (start_write |=> mem_addr_o == $past(stack_reg) + 32'h00000001)
        else $error("push address is not pointer plus one");
    pop_addr_a: assert property (start_read |=> mem_addr_o == $past(stack_reg) && !mem_we_o)
        else $error("pop address is not the pointer");
    push_incr_a: assert property (write_done |=> stack_reg == $past(stack_reg) + 32'h00000001)
        else $error("pointer not incremented after push");
    pop_decr_a: assert property (read_done |=> stack_reg == $past(stack_reg) - 32'h00000001)
        else $error("pointer not decremented after pop");
    entry_gate_a: assert property (irq_ack_o |-> $past(global_irq_enable_o)
                                   && $past(|(irq_flag_o & irq_enable_mask_o)))
        else $error("entry without enabled pending request");
    // Push request already stands in the cycle after entry, even with a zero-wait ack
    entry_gie_a: assert property (irq_take |=>
                                  !global_irq_enable_o && mem_req_o && mem_we_o)
        else $error("global enable not cleared on entry");
    entry_vector_a: assert property (entry_push_s |=>
                                     pc_load_o && pc_value_o == VECTOR_BASE + PC_W'(irq_ack_idx_o))
        else $error("wrong vector loaded on entry");
    entry_prio_a: assert property (irq_take |->
                                   (pending & ((IRQ_N'(1) << irq_sel) - IRQ_N'(1))) == '0)
        else $error("lower pending source skipped");
    flag_set_a: assert property (|irq_rise |=> (irq_flag_o & $past(irq_rise)) == $past(irq_rise))
        else $error("request edge did not set its flag");
    float_zero_a: assert property (read_done && kind_reg == OP_POP_FLT |=>
                                   reg_wr_o && reg_wr_data_o[FLT_LSB_W-1:0] == FLT_ZERO)
        else $error("float pop left low bits set");
    reti_gie_a: assert property (irq_return_s |=> global_irq_enable_o && pc_load_o)
        else $error("interrupt return did not re-enable");

endmodule

// *** bench/stack_mem_model.sv ***
`timescale 1ns/100ps
module stack_mem_model
    import cpu_stack_irq_pkg::*;
(
    input  wire logic              clk_sys_i,
    input  wire logic [3:0]        lat_i,
    input  wire logic              req_i,
    input  wire logic              we_i,
    input  wire logic [DATA_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    output logic                   ack_o,
    output logic [DATA_W-1:0]      rdata_o
);
    logic [DATA_W-1:0] mem [256];
    logic [3:0]        wait_cnt;

    initial
    begin
        ack_o    = 1'b0;
        rdata_o  = 32'h00000000;
        wait_cnt = 4'h0;
    end

    // One ack per request, only while the request stands
    always @(posedge clk_sys_i)
    begin
        #1;
        if (ack_o)
        begin
            ack_o   = 1'b0;
            // Released bus shows the inverse so a stale word never passes
            rdata_o = ~rdata_o;
        end
        else if (req_i)
        begin
            if (wait_cnt < lat_i)
                wait_cnt = wait_cnt + 4'h1;
            else
            begin
                wait_cnt = 4'h0;
                ack_o    = 1'b1;
                if (we_i)
                    mem[addr_i[7:0]] = wdata_i;
                else
                    rdata_o = mem[addr_i[7:0]];
            end
        end
    end
endmodule

// *** bench/tb_cpu_stack_interrupt_entry.sv ***
`timescale 1ns/100ps
module tb_cpu_stack_interrupt_entry
    import cpu_stack_irq_pkg::*;
;
    logic        clk_sys_i, rst_n_i, op_valid_i, op_cond_i, mem_ack_i;
    logic [3:0]  op_code_i, irq_req_i, lat;
    logic [4:0]  op_reg_i;
    logic [31:0] op_wdata_i, mem_rdata_i, mem_addr_o, mem_wdata_o, sp;
    logic [39:0] op_ext_i, reg_wr_data_o, got_wdata;
    logic [23:0] op_ret_pc_i, op_target_i, irq_ret_pc_i, pc_value_o, got_pc;
    logic        op_ready_o, op_done_o, op_error_o, mem_req_o, mem_we_o, pc_load_o;
    logic        reg_wr_o, irq_ack_o, global_irq_enable_o, got_load, got_wr, got_err;
    logic [4:0]  reg_wr_idx_o;
    logic [1:0]  irq_ack_idx_o;
    logic [31:0] stack_top_pointer_o, cpu_status_word_o;
    logic [3:0]  irq_flag_o, irq_enable_mask_o;
    int          checks, miscompares, cycles;

    cpu_stack_irq_entry u_cpu_stack_irq_entry (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i),
        .op_code_i(op_code_i), .op_cond_i(op_cond_i), .op_reg_i(op_reg_i),
        .op_wdata_i(op_wdata_i), .op_ext_i(op_ext_i), .op_ret_pc_i(op_ret_pc_i),
        .op_target_i(op_target_i), .irq_ret_pc_i(irq_ret_pc_i), .irq_req_i(irq_req_i),
        .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i), .op_ready_o(op_ready_o),
        .op_done_o(op_done_o), .op_error_o(op_error_o), .mem_req_o(mem_req_o),
        .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
        .pc_load_o(pc_load_o), .pc_value_o(pc_value_o), .reg_wr_o(reg_wr_o),
        .reg_wr_idx_o(reg_wr_idx_o), .reg_wr_data_o(reg_wr_data_o), .irq_ack_o(irq_ack_o),
        .irq_ack_idx_o(irq_ack_idx_o), .stack_top_pointer_o(stack_top_pointer_o),
        .irq_flag_o(irq_flag_o), .irq_enable_mask_o(irq_enable_mask_o),
        .cpu_status_word_o(cpu_status_word_o), .global_irq_enable_o(global_irq_enable_o));

    stack_mem_model u_stack_mem_model (
        .clk_sys_i(clk_sys_i), .lat_i(lat), .req_i(mem_req_o), .we_i(mem_we_o),
        .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checks = checks + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Done pulse stands one cycle, so everything it qualifies is caught here
    task automatic wait_done();
        int n;
        n = 0;
        @(negedge clk_sys_i);
        while (op_done_o !== 1'b1 && n < 100)
        begin
            n++;
            @(negedge clk_sys_i);
        end
        chk(op_done_o, 1'b1);
        got_load  = pc_load_o;
        got_pc    = pc_value_o;
        got_wr    = reg_wr_o;
        got_wdata = reg_wr_data_o;
        got_err   = op_error_o;
    endtask

    // Request held until the edge that samples ready high
    task automatic do_op(input op_e code, input logic cond, input logic [4:0] idx,
                         input logic [31:0] wd, input logic [39:0] ext);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        #1;
        op_valid_i = 1'b1;
        op_code_i  = code;
        op_cond_i  = cond;
        op_reg_i   = idx;
        op_wdata_i = wd;
        op_ext_i   = ext;
        @(negedge clk_sys_i);
        while (op_ready_o !== 1'b1 && n < 100)
        begin
            n++;
            @(negedge clk_sys_i);
        end
        @(posedge clk_sys_i);
        #1;
        op_valid_i = 1'b0;
        wait_done();
    endtask

    task automatic pulse(input logic [3:0] pins);
        @(posedge clk_sys_i);
        #1;
        irq_req_i = pins;
        repeat (2) @(posedge clk_sys_i);
        #1;
        irq_req_i = 4'h0;
        repeat (6) @(negedge clk_sys_i);
    endtask

    task automatic wait_entry(input logic [1:0] idx, input logic [3:0] left);
        int n;
        n = 0;
        @(negedge clk_sys_i);
        while (irq_ack_o !== 1'b1 && n < 100)
        begin
            n++;
            @(negedge clk_sys_i);
        end
        chk(irq_ack_o, 1'b1);
        chk(irq_ack_idx_o, idx);
        chk(global_irq_enable_o, 1'b0);
        chk(irq_flag_o, left);
        wait_done();
        sp = sp + 32'h1;
        chk(got_pc, VECTOR_BASE + idx);
        chk(stack_top_pointer_o, sp);
        chk(u_stack_mem_model.mem[sp[7:0]], {PC_PAD, irq_ret_pc_i});
    endtask

    always @(posedge clk_sys_i)
    begin
        cycles = cycles + 1;
        // Whole run needs a few hundred cycles at most
        if (cycles == 20000)
        begin
            miscompares = miscompares + 1;
            wrap_up();
        end
    end

    initial
    begin
        {rst_n_i, op_valid_i, op_cond_i, op_code_i, op_reg_i, irq_req_i} = '0;
        {op_wdata_i, op_ext_i, op_ret_pc_i, op_target_i} = '0;
        irq_ret_pc_i = 24'h123456;
        lat          = 4'h0;
        checks       = 0;
        miscompares  = 0;
        cycles       = 0;
        repeat (6) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        do_op(OP_PTR_WRITE, 1'b1, 5'h00, 32'h00000010, 40'h0);
        sp = 32'h00000010;
        chk(stack_top_pointer_o, sp);
        do_op(OP_STATUS_WRITE, 1'b1, 5'h00, 32'h00002000, 40'h0);
        chk(global_irq_enable_o, 1'b1);
        do_op(OP_MASK_WRITE, 1'b1, 5'h00, 32'h00000005, 40'h0);
        @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        @(negedge clk_sys_i);
        chk(stack_top_pointer_o, sp);
        chk({cpu_status_word_o, irq_enable_mask_o, irq_flag_o}, 40'h0);
        // Status word goes on the stack first and comes off last
        do_op(OP_STATUS_WRITE, 1'b1, 5'h00, 32'h00000055, 40'h0);
        do_op(OP_PUSH_INT, 1'b1, 5'h15, 32'h0, {8'h00, cpu_status_word_o});
        sp = sp + 32'h1;
        chk(u_stack_mem_model.mem[sp[7:0]], 32'h00000055);
        do_op(OP_PUSH_INT, 1'b1, 5'h02, 32'h0, 40'hAB12345678);
        sp = sp + 32'h1;
        chk(stack_top_pointer_o, sp);
        chk(u_stack_mem_model.mem[sp[7:0]], 32'h12345678);
        lat = 4'h3;
        do_op(OP_PUSH_FLT, 1'b1, 5'h02, 32'h0, 40'hAB12345678);
        sp = sp + 32'h1;
        chk(u_stack_mem_model.mem[sp[7:0]], 32'hAB123456);
        do_op(OP_POP_FLT, 1'b1, 5'h02, 32'h0, 40'h0);
        sp = sp - 32'h1;
        chk({got_wr, reg_wr_idx_o}, {1'b1, 5'h02});
        chk(got_wdata, 40'hAB12345600);
        chk(stack_top_pointer_o, sp);
        do_op(OP_POP_INT, 1'b1, 5'h02, 32'h0, 40'hAB12345600);
        sp = sp - 32'h1;
        chk(got_wdata, 40'hAB12345678);
        do_op(OP_POP_INT, 1'b1, 5'h15, 32'h0, 40'h0);
        sp = sp - 32'h1;
        chk(got_wdata, 40'h0000000055);
        chk(stack_top_pointer_o, sp);
        lat = 4'h0;
        do_op(OP_PUSH_FLT, 1'b1, 5'h08, 32'h0, 40'h1);
        chk({got_err, got_wr, stack_top_pointer_o}, {2'b10, sp});
        do_op(OP_POP_FLT, 1'b1, 5'h08, 32'h0, 40'h1);
        chk({got_err, got_wr, stack_top_pointer_o}, {2'b10, sp});
        op_ret_pc_i = 24'h00ABCD;
        op_target_i = 24'h000400;
        do_op(OP_CALL, 1'b0, 5'h00, 32'h0, 40'h0);
        chk({got_load, stack_top_pointer_o}, {1'b0, sp});
        do_op(OP_CALL, 1'b1, 5'h00, 32'h0, 40'h0);
        sp = sp + 32'h1;
        chk({got_load, got_pc}, {1'b1, 24'h000400});
        chk(u_stack_mem_model.mem[sp[7:0]], 32'h0000ABCD);
        // Junk in the top byte must not reach the 24-bit PC
        u_stack_mem_model.mem[sp[7:0]] = 32'hFF00ABCD;
        do_op(OP_RET_SUB, 1'b0, 5'h00, 32'h0, 40'h0);
        chk({got_load, stack_top_pointer_o}, {1'b0, sp});
        do_op(OP_RET_SUB, 1'b1, 5'h00, 32'h0, 40'h0);
        sp = sp - 32'h1;
        chk({got_load, got_pc}, {1'b1, 24'h00ABCD});
        chk(stack_top_pointer_o, sp);
        pulse(4'hA);
        chk(irq_flag_o, 4'hA);
        do_op(OP_RET_IRQ, 1'b0, 5'h00, 32'h0, 40'h0);
        chk({got_load, global_irq_enable_o, stack_top_pointer_o}, {2'b00, sp});
        do_op(OP_FLAG_WRITE, 1'b1, 5'h00, 32'h00000000, 40'h0);
        chk(irq_flag_o, 4'h0);
        pulse(4'hA);
        do_op(OP_MASK_WRITE, 1'b1, 5'h00, 32'h00000008, 40'h0);
        lat = 4'h2;
        do_op(OP_STATUS_WRITE, 1'b1, 5'h00, 32'h00002000, 40'h0);
        wait_entry(2'd3, 4'h2);
        do_op(OP_RET_IRQ, 1'b1, 5'h00, 32'h0, 40'h0);
        sp = sp - 32'h1;
        chk({got_pc, global_irq_enable_o}, {24'h123456, 1'b1});
        repeat (5) @(negedge clk_sys_i);
        chk({irq_ack_o, irq_flag_o}, {1'b0, 4'h2});
        do_op(OP_MASK_WRITE, 1'b1, 5'h00, 32'h0000000F, 40'h0);
        wait_entry(2'd1, 4'h0);
        do_op(OP_RET_IRQ, 1'b1, 5'h00, 32'h0, 40'h0);
        sp = sp - 32'h1;
        do_op(OP_FLAG_WRITE, 1'b1, 5'h00, 32'h0000000C, 40'h0);
        wait_entry(2'd2, 4'h8);
        do_op(OP_RET_IRQ, 1'b1, 5'h00, 32'h0, 40'h0);
        sp = sp - 32'h1;
        wait_entry(2'd3, 4'h0);
        do_op(OP_RET_IRQ, 1'b1, 5'h00, 32'h0, 40'h0);
        sp = sp - 32'h1;
        chk({stack_top_pointer_o, global_irq_enable_o}, {sp, 1'b1});
        wrap_up();
    end
endmodule
